// ### hw/egress_vlan_tag_editor.sv
// Function
// - five ordered steps per frame and destination
// - lookup only when enabled, action steers push
// - pop header pop count, zero to three
// - lookup hit may add one pop
// - never pop more than tags present
// - decide zero to three new tags
// - sources: port, lookup tag A, mirror, cpu
// - mirror and cpu tags sit outermost
// - with MPLS, special tags follow SMAC
// - require prior tag gates port tag unless outer select two forces it
// - three custom TPIDs chosen per port
// - four port tag modes on classified VID
// - port tag VID classified or default
// - default VID also means send untagged
// - no hit or selects zero: port tag
// - outer select one pushes tag A
// - drop precedence mapped to drop eligible
// - per port pcp/dei remap tables
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps

module egress_vlan_tag_editor #(
	parameter int PORTS = 4,
	parameter int RULES = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic in_valid,
	input wire vlan_edit_pkg::frame_in_s in_frame,
	output logic in_ready,
	output logic out_valid,
	output vlan_edit_pkg::frame_out_s out_frame,
	input wire logic out_ready
);
	import vlan_edit_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	localparam int PW = (PORTS > 1) ? $clog2(PORTS) : 1;
	localparam int RW = (RULES > 1) ? $clog2(RULES) : 1;

	typedef enum logic [2:0] {ST_IDLE, ST_LOOKUP, ST_POP, ST_DECIDE, ST_BUILD, ST_PUSH} state_e;

	typedef struct packed {
		state_e st;
		logic lookup_en; // global lookup enable
		logic [3:0] drop_level_map; // drop eligible per drop precedence
		spec_cfg_s mirror_cfg;
		spec_cfg_s cpu_tag_select;
		logic [2:0][15:0] custom_tag_protocol_id;
		port_vlan_s [PORTS-1:0] pvlan;
		tag_ctrl_s [PORTS-1:0] tctrl;
		logic [PORTS-1:0][1:0][23:0] pcp_remap_table; // [port][de][class]
		logic [PORTS-1:0][15:0] dei_remap_table; // bit {de,class}
		rule_key_s [RULES-1:0] rkey;
		rule_act_s [RULES-1:0] ract;
		logic [15:0] frame_cnt; // frames handed downstream
		frame_in_s fr; // frame under edit
		logic hit;
		rule_act_s act;
		logic [1:0] pop;
		logic push_port;
		logic push_a;
		frame_out_s out;
		logic out_valid;
		logic in_ready;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_s;

	state_s q;
	state_s d;
	logic m_hit; // lookup match, raw
	rule_act_s m_act; // lookup action, raw

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// pick TPID
	function automatic logic [15:0] tpid_of(input logic [1:0] sel, input logic [2:0][15:0] tp);
		tpid_of = (sel == 2'h0) ? STD_TPID : tp[sel - 2'h1];
	endfunction

	// a leading ethertype counts as a tag if it is any known TPID
	function automatic logic is_tag(input logic [15:0] et, input logic [2:0][15:0] tp);
		is_tag = (et == STD_TPID) || (et == tp[0]) || (et == tp[1]) || (et == tp[2]);
	endfunction

	function automatic tag_s spec_tag(input spec_cfg_s c, input logic [2:0][15:0] tp);
		spec_tag = '{tpid: tpid_of(c.tpid_sel, tp), pcp: c.pcp, dei: c.dei, vid: c.vid};
	endfunction

	// ----------------------------------------------------------------
	// lookup table compare
	// ----------------------------------------------------------------
	rule_match #(
		.RULES(RULES)
	) u_match (
		.key_vid(q.fr.classified_vid),
		.keys(q.rkey),
		.acts(q.ract),
		.hit(m_hit),
		.act(m_act)
	);

	// ----------------------------------------------------------------
	// next state: register bus and frame steps
	// ----------------------------------------------------------------
	always_comb
	begin
		logic rd; // setup cycle
		logic wr; // completing write
		logic err;
		logic [31:0] rdata;
		logic [PW-1:0] pi; // bus port index
		logic [RW-1:0] ri; // bus rule index
		logic [PW-1:0] fp; // frame port index
		logic [2:0] req;
		logic [1:0] present;
		logic [1:0] outer;
		logic mode_ok;
		logic de;
		logic [2:0] n;
		tag_s pt;
		d = q;
		rd = psel && !penable;
		wr = psel && penable && q.pready && pwrite;
		err = 1'b0;
		rdata = '0;
		pi = paddr[5 +: PW];
		ri = paddr[3 +: RW];
		fp = q.fr.dst_port[PW-1:0];
		req = '0;
		present = '0;
		outer = OUTER_PORT_MODE;
		mode_ok = 1'b0;
		de = q.drop_level_map[q.fr.drop_precedence];
		n = '0;
		pt = '0;

		// one decode serves the read at setup and the write at completion
		unique case (paddr[11:8])
			GLOBAL_REGION:
			begin
				case (paddr[7:0])
					CTRL_OFS:
					begin
						rdata = {31'h0, q.lookup_en};
						if (wr) d.lookup_en = pwdata[0];
					end
					// read-only, writes ignored
					STATUS_OFS: rdata = {q.st != ST_IDLE, 15'h0, q.frame_cnt};
					DROP_MAP_OFS:
					begin
						rdata = {28'h0, q.drop_level_map};
						if (wr) d.drop_level_map = pwdata[3:0];
					end
					MIRROR_TAG_OFS:
					begin
						rdata = 32'(q.mirror_cfg);
						if (wr) d.mirror_cfg = pwdata[$bits(spec_cfg_s)-1:0];
					end
					CPU_TAG_OFS:
					begin
						rdata = 32'(q.cpu_tag_select);
						if (wr) d.cpu_tag_select = pwdata[$bits(spec_cfg_s)-1:0];
					end
					TPID0_OFS, TPID1_OFS, TPID2_OFS:
					begin
						rdata = {16'h0, q.custom_tag_protocol_id[paddr[3:2] - 2'h1]};
						if (wr) d.custom_tag_protocol_id[paddr[3:2] - 2'h1] = pwdata[15:0];
					end
					default: err = 1'b1;
				endcase
			end
			PORT_REGION:
			begin
				// ports above the configured count are unmapped
				if (int'(paddr[7:5]) >= PORTS) err = 1'b1;
				else
				begin
					case (paddr[4:0])
						PORT_VLAN_OFS:
						begin
							rdata = 32'(q.pvlan[pi]);
							if (wr) d.pvlan[pi] = pwdata[$bits(port_vlan_s)-1:0];
						end
						TAG_CTRL_OFS:
						begin
							rdata = 32'(q.tctrl[pi]);
							if (wr) d.tctrl[pi] = pwdata[$bits(tag_ctrl_s)-1:0];
						end
						PCP_MAP0_OFS, PCP_MAP1_OFS:
						begin
							rdata = {8'h0, q.pcp_remap_table[pi][paddr[2]]};
							if (wr) d.pcp_remap_table[pi][paddr[2]] = pwdata[23:0];
						end
						DEI_MAP_OFS:
						begin
							rdata = {16'h0, q.dei_remap_table[pi]};
							if (wr) d.dei_remap_table[pi] = pwdata[15:0];
						end
						default: err = 1'b1;
					endcase
				end
			end
			RULE_REGION:
			begin
				if (int'(paddr[7:3]) >= RULES) err = 1'b1;
				else if (paddr[2:0] == RULE_KEY_OFS)
				begin
					rdata = 32'(q.rkey[ri]);
					if (wr) d.rkey[ri] = pwdata[$bits(rule_key_s)-1:0];
				end
				else if (paddr[2:0] == RULE_ACT_OFS)
				begin
					rdata = 32'(q.ract[ri]);
					if (wr) d.ract[ri] = pwdata[$bits(rule_act_s)-1:0];
				end
				else err = 1'b1;
			end
			default: err = 1'b1;
		endcase

		// answer one cycle after setup: no wait states
		d.pready = rd;
		d.pslverr = rd && err;
		if (rd && !pwrite) d.prdata = rdata;

		unique case (q.st)
			ST_IDLE:
			begin
				if (in_valid && q.in_ready)
				begin
					d.fr = in_frame;
					d.in_ready = 1'b0;
					d.st = ST_LOOKUP;
				end
			end
			ST_LOOKUP:
			begin
				d.hit = q.lookup_en && m_hit;
				d.act = m_act;
				d.st = ST_POP;
			end
			ST_POP:
			begin
				// count consecutive leading tags
				if (is_tag(q.fr.lead_etype[0], q.custom_tag_protocol_id))
				begin
					present = 2'h1;
					if (is_tag(q.fr.lead_etype[1], q.custom_tag_protocol_id))
					begin
						present = 2'h2;
						if (is_tag(q.fr.lead_etype[2], q.custom_tag_protocol_id))
							present = 2'h3;
					end
				end
				req = {1'b0, q.fr.header_pop_count} + {2'h0, q.hit && q.act.lookup_pop_increment};
				d.pop = (req > {1'b0, present}) ? present : req[1:0];
				d.st = ST_DECIDE;
			end
			ST_DECIDE:
			begin
				unique case (q.tctrl[fp].mode)
					TAG_ALL: mode_ok = 1'b1;
					TAG_EXCEPT_ZERO_DEFAULT: mode_ok = (q.fr.classified_vid != 12'h000)
						&& (q.fr.classified_vid != q.pvlan[fp].port_default_vid);
					TAG_EXCEPT_ZERO: mode_ok = (q.fr.classified_vid != 12'h000);
					TAG_NONE: mode_ok = 1'b0;
				endcase
				if (q.tctrl[fp].port_tag_require_prior_tag && !q.fr.arrived_tagged_flag)
					mode_ok = 1'b0;
				// no hit, port tag
				// inner select is not decoded: no inner tag is ever pushed
				if (q.hit) outer = q.act.outer_sel;
				d.push_a = (outer == OUTER_TAG_A);
				// port tag only for a configured destination port
				d.push_port = (int'(q.fr.dst_port) < PORTS)
					&& (((outer == OUTER_PORT_MODE) && mode_ok) || (outer == OUTER_PORT_FORCED));
				d.st = ST_BUILD;
			end
			ST_BUILD:
			begin
				pt.tpid = tpid_of(q.tctrl[fp].port_tpid_select, q.custom_tag_protocol_id);
				pt.vid = q.tctrl[fp].port_default_vid_select ? q.pvlan[fp].port_default_vid
					: q.fr.classified_vid;
				unique case (q.tctrl[fp].port_pcp_select)
					FIELD_CLASSIFIED: pt.pcp = q.fr.cls_pcp;
					FIELD_PORT: pt.pcp = q.pvlan[fp].pcp;
					default: pt.pcp = q.pcp_remap_table[fp][de][3 * int'(q.fr.qos_class) +: 3];
				endcase
				unique case (q.tctrl[fp].port_dei_select)
					FIELD_CLASSIFIED: pt.dei = q.fr.cls_dei;
					FIELD_PORT: pt.dei = q.pvlan[fp].dei;
					default: pt.dei = q.dei_remap_table[fp][{de, q.fr.qos_class}];
				endcase
				d.out = '0;
				d.out.dst_port = q.fr.dst_port;
				d.out.pop_total = q.pop;
				if (q.fr.mirrored && q.mirror_cfg.enable)
				begin
					d.out.push_stack[n[1:0]] = spec_tag(q.mirror_cfg, q.custom_tag_protocol_id);
					n = n + 3'h1;
				end
				if (q.fr.to_cpu && q.cpu_tag_select.enable)
				begin
					d.out.push_stack[n[1:0]] = spec_tag(q.cpu_tag_select, q.custom_tag_protocol_id);
					n = n + 3'h1;
				end
				d.out.after_mpls_smac = q.fr.mpls_encap && (n != 3'h0);
				if (q.push_a)
				begin
					d.out.push_stack[n[1:0]] = '{tpid: tpid_of(q.act.tpid_sel,
						q.custom_tag_protocol_id), pcp: q.act.pcp, dei: q.act.dei, vid: q.act.vid};
					n = n + 3'h1;
				end
				else if (q.push_port)
				begin
					d.out.push_stack[n[1:0]] = pt;
					n = n + 3'h1;
				end
				d.out.push_count = n;
				d.out_valid = 1'b1;
				d.st = ST_PUSH;
			end
			ST_PUSH:
			begin
				// hold the result until downstream takes it
				if (out_ready)
				begin
					d.out_valid = 1'b0;
					d.in_ready = 1'b1;
					d.frame_cnt = q.frame_cnt + 16'h1;
					d.st = ST_IDLE;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= '0;
			q.st <= ST_IDLE;
			q.in_ready <= 1'b1;
			q.drop_level_map <= DROP_MAP_RST;
			q.custom_tag_protocol_id <= {3{TPID_RST}};
			for (int i = 0; i < PORTS; i++)
				q.pvlan[i].port_default_vid <= PORT_DEFAULT_VID_RST;
		end
		else
			q <= d;
	end

	// outputs straight from the state register
	assign pready = q.pready;
	assign prdata = q.prdata;
	assign pslverr = q.pslverr;
	assign in_ready = q.in_ready;
	assign out_valid = q.out_valid;
	assign out_frame = q.out;

endmodule

// ### hw/rule_match.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// egress rule lookup: lowest matching entry wins
// ----------------------------------------------------------------
module rule_match #(
	parameter int RULES = 4
) (
	input wire logic [11:0] key_vid,
	input wire vlan_edit_pkg::rule_key_s [RULES-1:0] keys,
	input wire vlan_edit_pkg::rule_act_s [RULES-1:0] acts,
	output logic hit,
	output vlan_edit_pkg::rule_act_s act
);
	import vlan_edit_pkg::*;

	// scan downward so the lowest index is the last to write
	always_comb
	begin
		hit = 1'b0;
		act = '0;
		for (int i = RULES - 1; i >= 0; i--)
		begin
			// only armed entries take part
			if (keys[i].valid && keys[i].vid == key_vid)
			begin
				hit = 1'b1;
				act = acts[i];
			end
		end
	end

endmodule

// ### include/vlan_edit_pkg.sv
package vlan_edit_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, one 32-bit word each)
	// ----------------------------------------------------------------
	localparam logic [3:0] GLOBAL_REGION = 4'h0;
	localparam logic [3:0] PORT_REGION = 4'h1;
	localparam logic [3:0] RULE_REGION = 4'h2;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] DROP_MAP_OFS = 8'h08;
	localparam logic [7:0] MIRROR_TAG_OFS = 8'h0C;
	localparam logic [7:0] CPU_TAG_OFS = 8'h10;
	localparam logic [7:0] TPID0_OFS = 8'h14;
	localparam logic [7:0] TPID1_OFS = 8'h18;
	localparam logic [7:0] TPID2_OFS = 8'h1C;
	// per port: index in paddr[7:5], word in paddr[4:0]
	localparam logic [4:0] PORT_VLAN_OFS = 5'h00;
	localparam logic [4:0] TAG_CTRL_OFS = 5'h04;
	localparam logic [4:0] PCP_MAP0_OFS = 5'h08;
	localparam logic [4:0] PCP_MAP1_OFS = 5'h0C;
	localparam logic [4:0] DEI_MAP_OFS = 5'h10;
	// per rule: index in paddr[7:3], word in paddr[2:0]
	localparam logic [2:0] RULE_KEY_OFS = 3'h0;
	localparam logic [2:0] RULE_ACT_OFS = 3'h4;

	// ----------------------------------------------------------------
	// reset values and fixed codes
	// ----------------------------------------------------------------
	localparam logic [15:0] STD_TPID = 16'h8100;
	localparam logic [15:0] TPID_RST = 16'h88A8;
	localparam logic [3:0] DROP_MAP_RST = 4'hC;
	localparam logic [11:0] PORT_DEFAULT_VID_RST = 12'h001;
	// port tag modes
	localparam logic [1:0] TAG_ALL = 2'h0;
	localparam logic [1:0] TAG_EXCEPT_ZERO_DEFAULT = 2'h1;
	localparam logic [1:0] TAG_EXCEPT_ZERO = 2'h2;
	localparam logic [1:0] TAG_NONE = 2'h3;
	// pcp / dei field sources
	localparam logic [1:0] FIELD_CLASSIFIED = 2'h0;
	localparam logic [1:0] FIELD_PORT = 2'h1;
	// outer push selects
	localparam logic [1:0] OUTER_PORT_MODE = 2'h0;
	localparam logic [1:0] OUTER_TAG_A = 2'h1;
	localparam logic [1:0] OUTER_PORT_FORCED = 2'h2;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] tpid;
		logic [2:0] pcp;
		logic dei;
		logic [11:0] vid;
	} tag_s;

	typedef struct packed {
		logic dei;
		logic [2:0] pcp;
		logic [11:0] port_default_vid;
	} port_vlan_s;

	typedef struct packed {
		logic [1:0] port_dei_select;
		logic [1:0] port_pcp_select;
		logic port_default_vid_select;
		logic [1:0] port_tpid_select;
		logic port_tag_require_prior_tag;
		logic [1:0] mode;
	} tag_ctrl_s;

	typedef struct packed {
		logic enable;
		logic [1:0] tpid_sel;
		logic [2:0] pcp;
		logic dei;
		logic [11:0] vid;
	} spec_cfg_s;

	typedef struct packed {
		logic valid;
		logic [11:0] vid;
	} rule_key_s;

	typedef struct packed {
		logic [1:0] tpid_sel;
		logic inner_sel;
		logic [1:0] outer_sel;
		logic lookup_pop_increment;
		logic [2:0] pcp;
		logic dei;
		logic [11:0] vid;
	} rule_act_s;

	typedef struct packed {
		logic [3:0] dst_port;
		logic [1:0] header_pop_count;
		logic arrived_tagged_flag;
		logic mirrored;
		logic to_cpu;
		logic mpls_encap;
		logic [11:0] classified_vid;
		logic [2:0] cls_pcp;
		logic cls_dei;
		logic [2:0] qos_class;
		logic [1:0] drop_precedence;
		logic [2:0][15:0] lead_etype;
	} frame_in_s;

	typedef struct packed {
		logic [3:0] dst_port;
		logic [1:0] pop_total;
		logic [2:0] push_count;
		logic after_mpls_smac;
		tag_s [3:0] push_stack;
	} frame_out_s;

endpackage

// ### tb/egress_vlan_tag_editor_tb.sv
`timescale 1ns/1ps

module egress_vlan_tag_editor_tb;
	import vlan_edit_pkg::*;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, e;
	logic in_valid, in_ready, out_valid, out_ready, go;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	frame_in_s in_frame, desc, f;
	frame_out_s out_frame, o;
	int failures = 0;
	int cmp_count = 0;
	int nfr = 0; // frames sent
	logic [11:0] vids [3] = '{12'h000, 12'h001, 12'h005};
	logic [11:0] tbl = 12'h1A7; // bit mode*3+i: port tag expected

	always #25 pclk = ~pclk;

	egress_vlan_tag_editor #(.PORTS(4), .RULES(4)) u_egress_vlan_tag_editor (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.in_valid(in_valid), .in_frame(in_frame), .in_ready(in_ready),
		.out_valid(out_valid), .out_frame(out_frame), .out_ready(out_ready));
	frame_source u_frame_source (.pclk(pclk), .presetn(presetn), .go(go), .desc(desc),
		.in_ready(in_ready), .in_valid(in_valid), .in_frame(in_frame));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer, held until ready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		r = prdata;
		e = pslverr;
		if (pready !== 1'b1)
			failures++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
		chk({31'h0, e}, 32'h0);
	endtask

	// send one frame, stall the result a cycle, then take it
	task automatic run(input frame_in_s fr);
		int n;
		n = 0;
		@(posedge pclk);
		go <= 1'b1;
		desc <= fr;
		@(posedge pclk);
		go <= 1'b0;
		while (out_valid !== 1'b1 && n < 50)
		begin
			@(posedge pclk);
			n++;
		end
		if (out_valid !== 1'b1)
			failures++;
		o = out_frame;
		nfr++;
		@(posedge pclk);
		out_ready <= 1'b1;
		@(posedge pclk);
		out_ready <= 1'b0;
	endtask

	function automatic frame_in_s base(input logic [11:0] vid);
		frame_in_s b;
		b = '0;
		b.classified_vid = vid;
		b.cls_pcp = 3'h3;
		b.arrived_tagged_flag = 1'b1;
		b.lead_etype = {16'h0800, 16'h0800, 16'h0800};
		return b;
	endfunction

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// watchdog, far beyond the expected run
	initial
	begin
		repeat (20000) @(posedge pclk);
		failures++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		{presetn, psel, penable, pwrite, go, out_ready} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		desc = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h014, 32'h0000_88A8);
		rd(12'h008, 32'h0000_000C);
		rd(12'h100, 32'h0000_0001);
		rd(12'h104, 32'h0000_0000);
		apb(1'b0, 12'h300, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("test registers done");
		for (int m = 0; m < 4; m++)
		begin
			wr(12'h104, m);
			for (int i = 0; i < 3; i++)
			begin
				run(base(vids[i]));
				chk({29'h0, o.push_count}, {31'h0, tbl[m*3+i]});
				if (tbl[m*3+i])
					chk(o.push_stack[0], {STD_TPID, 3'h3, 1'b0, vids[i]});
			end
		end
		$display("test modes done");
		wr(12'h014, 32'h0000_9100);
		wr(12'h100, 32'h0000_A02A);
		wr(12'h104, 32'h0000_0168);
		run(base(12'h005));
		chk(o.push_stack[0], {16'h9100, 3'h2, 1'b1, 12'h02A});
		wr(12'h104, 32'h0000_0004);
		f = base(12'h005);
		f.arrived_tagged_flag = 1'b0;
		run(f);
		chk({29'h0, o.push_count}, 32'h0);
		run(base(12'h005));
		chk({29'h0, o.push_count}, 32'h1);
		$display("test port fields done");
		wr(12'h104, 32'h0000_0280);
		wr(12'h10C, 32'h0000_0A00);
		wr(12'h110, 32'h0000_0800);
		f = base(12'h005);
		f.qos_class = 3'h3;
		f.drop_precedence = 2'h2;
		run(f);
		chk(o.push_stack[0], {STD_TPID, 3'h5, 1'b1, 12'h005});
		f.drop_precedence = 2'h1;
		run(f);
		chk(o.push_stack[0], {STD_TPID, 3'h0, 1'b0, 12'h005});
		$display("test remap done");
		wr(12'h104, 32'h0000_0003);
		f = base(12'h007);
		f.header_pop_count = 2'h3;
		// second tag uses custom TPID 1, so it must count as present too
		f.lead_etype = {16'h0800, 16'h9100, 16'h8100};
		run(f);
		chk({30'h0, o.pop_total}, 32'h2);
		wr(12'h200, 32'h0000_1007);
		wr(12'h204, 32'h0003_8123);
		wr(12'h000, 32'h0000_0001);
		f.header_pop_count = 2'h1;
		f.lead_etype = {16'h8100, 16'h8100, 16'h8100};
		run(f);
		chk({30'h0, o.pop_total}, 32'h2);
		chk({29'h0, o.push_count}, 32'h1);
		chk(o.push_stack[0], {STD_TPID, 3'h4, 1'b0, 12'h123});
		// outer select 2 forces the port tag although the mode says none
		wr(12'h204, 32'h0004_0123);
		run(f);
		chk({29'h0, o.push_count}, 32'h1);
		chk(o.push_stack[0], {STD_TPID, 3'h3, 1'b0, 12'h007});
		// outer select 3 pushes nothing
		wr(12'h204, 32'h0006_0123);
		run(f);
		chk({29'h0, o.push_count}, 32'h0);
		wr(12'h000, 32'h0000_0000);
		run(f);
		chk({30'h0, o.pop_total}, 32'h1);
		chk({29'h0, o.push_count}, 32'h0);
		chk({30'h0, o.pop_total}, {30'h0, f.header_pop_count});
		$display("test pop and lookup done");
		wr(12'h104, 32'h0000_0000);
		wr(12'h00C, 32'h0004_20AA);
		wr(12'h010, 32'h0004_C0BB);
		f = base(12'h005);
		{f.mirrored, f.to_cpu, f.mpls_encap} = 3'h7;
		run(f);
		chk({29'h0, o.push_count}, 32'h3);
		chk(o.push_stack[0], {STD_TPID, 3'h1, 1'b0, 12'h0AA});
		chk(o.push_stack[1], {STD_TPID, 3'h6, 1'b0, 12'h0BB});
		chk(o.push_stack[2], {STD_TPID, 3'h3, 1'b0, 12'h005});
		chk({31'h0, o.after_mpls_smac}, 32'h1);
		// unconfigured destination: special tags only, no port tag
		f.dst_port = 4'h5;
		run(f);
		chk({29'h0, o.push_count}, 32'h2);
		chk({28'h0, o.dst_port}, 32'h5);
		// status is read-only: this write must leave the count alone
		wr(12'h004, 32'hFFFF_FFFF);
		rd(12'h004, nfr);
		$display("test special tags done");
		report_and_stop();
	end
endmodule

// ### tb/frame_source.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// upstream stage: offers one descriptor and holds it until taken
// ----------------------------------------------------------------
module frame_source (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire vlan_edit_pkg::frame_in_s desc,
	input wire logic in_ready,
	output logic in_valid,
	output vlan_edit_pkg::frame_in_s in_frame
);
	import vlan_edit_pkg::*;

	// offer on go, release after the taking edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			in_valid <= 1'b0;
			in_frame <= '0;
		end
		else if (go)
		begin
			in_valid <= 1'b1;
			in_frame <= desc;
		end
		else if (in_valid && in_ready)
		begin
			// inverted so a late sample of stale data is caught
			in_valid <= 1'b0;
			in_frame <= ~in_frame;
		end
	end
endmodule

// ### tb/vlan_edit_checker.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// port timing and result content checks for the tag editor
// ----------------------------------------------------------------
module vlan_edit_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic in_valid,
	input wire vlan_edit_pkg::frame_in_s in_frame,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire vlan_edit_pkg::frame_out_s out_frame,
	input wire logic out_ready
);
	import vlan_edit_pkg::*;
	frame_in_s cap_q; // descriptor of the frame in flight
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// keep the taken descriptor, the source scrambles it afterwards
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cap_q <= '0;
		else if (in_valid && in_ready)
			cap_q <= in_frame;
	end

	// four busy steps, then the result appears
	sequence busy_s;
		(!out_valid && !in_ready) [*4];
	endsequence
	sequence steps_s;
		busy_s ##1 (out_valid && !in_ready);
	endsequence

	a_apb_zero_wait: assert property (psel && !penable |=> pready)
		else $error("apb ready missing after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("apb ready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("apb error without ready");
	a_five_steps: assert property (in_valid && in_ready |=> steps_s)
		else $error("result not five edges after take");
	a_result_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_frame))
		else $error("result changed while stalled");
	a_accept_frees: assert property (out_valid && out_ready |=> !out_valid && in_ready)
		else $error("editor not free after accept");
	a_push_limit: assert property (out_valid |-> out_frame.push_count <= 3'h3)
		else $error("too many tags pushed");
	a_pop_bound: assert property ($rose(out_valid) |->
		{1'b0, out_frame.pop_total} <= {1'b0, cap_q.header_pop_count} + 3'h1)
		else $error("pop count beyond header plus one");
	a_port_pairs: assert property ($rose(out_valid) |-> out_frame.dst_port == cap_q.dst_port)
		else $error("result port differs from descriptor");
	a_mpls_place: assert property ($rose(out_valid) && !cap_q.mpls_encap |->
		!out_frame.after_mpls_smac)
		else $error("mpls placement without mpls");
endmodule

bind egress_vlan_tag_editor vlan_edit_checker u_vlan_edit_checker (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.in_valid(in_valid), .in_frame(in_frame), .in_ready(in_ready), .out_valid(out_valid),
	.out_frame(out_frame), .out_ready(out_ready));
